//--- logic/kmw_cfg.svh
// Constants of the keyboard and mouse wake configuration block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef KMW_CFG_SVH
`define KMW_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_MHZ 200
`define DCLICK_MS 500
`define FRAME_TIMEOUT_US 100
`define DCLICK_CYCLES (`DCLICK_MS * 1000 * `CLK_MHZ)
`define FRAME_TIMEOUT_CYCLES (`FRAME_TIMEOUT_US * `CLK_MHZ)

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_KBD_WAKE_CTRL 6'h04
`define IDX_PROTO_CTRL 6'h05
`define IDX_KBD_CAPTURE 6'h06
`define IDX_MOUSE_CAPTURE 6'h07
`define IDX_KEY_FIRST 6'h08
`define IDX_KEY_LAST 6'h0F
`define IDX_WAKE_STATUS 6'h10
`define IDX_WAKE_MASK 6'h11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_KBD_WAKE_CTRL 8'h40
`define RST_PROTO_CTRL 8'h10
`define RST_BYTE 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_PARITY_OFF 7
`define MSB_MOUSE_SEL 6
`define LSB_MOUSE_SEL 4
`define MSB_KBD_SEL 3
`define BIT_PASSWORD 3
`define MSB_KBD_MODE 7
`define LSB_KBD_MODE 6
`define MSB_PM_EVT 5
`define MOUSE_SYNC_BIT 3
`define EV_KBD 0
`define EV_MOUSE 1
`define EV_PARITY 2

// ----------------------------------------------------------------
// Link byte codes and bus answers
// ----------------------------------------------------------------
`define KEY_WILDCARD 8'h00
`define SC_BREAK 8'hF0
`define SC_EXTEND 8'hE0
`define SC_LSHIFT 8'h12
`define SC_RSHIFT 8'h59
`define SC_ALT 8'h11
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_BITS_LAST 3'h7

`endif

//--- logic/kmw_pkg.sv
// Types of the keyboard and mouse wake configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package kmw_pkg;

	// ----------------------------------------------------------------
	// Link frame receiver states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_DATA = 4'h2,
		RX_PARITY = 4'h4,
		RX_STOP = 4'h8
	} rx_state_e;

	// ----------------------------------------------------------------
	// Keyboard wake modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		KBD_MODE_SEQ = 2'h0,
		KBD_MODE_ANY = 2'h1,
		KBD_MODE_PM = 2'h2,
		KBD_MODE_RSVD = 2'h3
	} kbd_mode_e;

	typedef logic [7:0] byte_t;

endpackage : kmw_pkg

//--- logic/ps2_frame_receiver.sv
// One listening end of a two-wire keyboard or mouse link.
// Assumes link clock and data are asynchronous pins; clk_in is much faster.
`timescale 1ns/10ps
`include "kmw_cfg.svh"

module ps2_frame_receiver
	import kmw_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = `FRAME_TIMEOUT_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic link_clk_in,
	input wire logic link_data_in,
	output logic byte_valid_out,
	output byte_t byte_out,
	output logic parity_ok_out
);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic clk_s1_q, clk_s2_q, clk_s3_q; // Link clock sync plus edge history
	logic dat_s1_q, dat_s2_q; // Link data sync
	logic fall_c; // Falling link clock edge

	// Two flops per pin, third only for edge detect
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			clk_s1_q <= 1'b1;
			clk_s2_q <= 1'b1;
			clk_s3_q <= 1'b1;
			dat_s1_q <= 1'b1;
			dat_s2_q <= 1'b1;
		end else begin
			clk_s1_q <= link_clk_in;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			dat_s1_q <= link_data_in;
			dat_s2_q <= dat_s1_q;
		end
	end

	assign fall_c = clk_s3_q & ~clk_s2_q;

	// ----------------------------------------------------------------
	// Frame state machine
	// ----------------------------------------------------------------
	rx_state_e state_q; // Frame position
	logic [2:0] bit_cnt_q; // Data bit count
	byte_t shift_q; // Data, least significant bit first
	logic par_q; // Received parity bit
	logic [31:0] idle_cnt_q; // Cycles since last edge inside a frame

	// Start, eight data, odd parity, stop; stalled frame is dropped
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= RX_IDLE;
			bit_cnt_q <= 3'h0;
			shift_q <= `RST_BYTE;
			par_q <= 1'b0;
			byte_valid_out <= 1'b0;
			byte_out <= `RST_BYTE;
			parity_ok_out <= 1'b0;
			idle_cnt_q <= 32'h0;
		end else begin
			byte_valid_out <= 1'b0;
			if (fall_c || state_q == RX_IDLE) begin
				idle_cnt_q <= 32'h0;
			end else begin
				idle_cnt_q <= idle_cnt_q + 32'h1;
			end
			if (state_q != RX_IDLE && idle_cnt_q >= TIMEOUT_CYCLES) begin
				// Other end stopped mid-frame
				state_q <= RX_IDLE;
			end else if (fall_c) begin
				case (state_q)
					RX_IDLE: begin
						if (!dat_s2_q) begin
							state_q <= RX_DATA;
							bit_cnt_q <= 3'h0;
						end
					end
					RX_DATA: begin
						shift_q <= {dat_s2_q, shift_q[7:1]};
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == `DATA_BITS_LAST) begin
							state_q <= RX_PARITY;
						end
					end
					RX_PARITY: begin
						par_q <= dat_s2_q;
						state_q <= RX_STOP;
					end
					RX_STOP: begin
						// Only a proper stop bit yields a byte
						if (dat_s2_q) begin
							byte_valid_out <= 1'b1;
							byte_out <= shift_q;
							parity_ok_out <= ^{shift_q, par_q};
						end
						state_q <= RX_IDLE;
					end
					default: begin
						state_q <= RX_IDLE;
					end
				endcase
			end
		end
	end

endmodule : ps2_frame_receiver

//--- logic/kbd_mouse_wake_config.sv
// Keyboard and mouse wake detector with its configuration registers.
// Assumes an AXI4-Lite master on clk_in and two listen-only link pin pairs.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "kmw_cfg.svh"

module kbd_mouse_wake_config
	import kmw_pkg::*;
#(
	parameter int unsigned DCLICK_CYCLES = `DCLICK_CYCLES,
	parameter int unsigned TIMEOUT_CYCLES = `FRAME_TIMEOUT_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	input wire logic kbd_clk_in,
	input wire logic kbd_data_in,
	input wire logic mouse_clk_in,
	input wire logic mouse_data_in,
	input wire logic wake_ack_in,
	output logic wake_event_out,
	output logic irq_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] aw_addr_q; // Held write address
	byte_t w_data_q; // Held write data, low lane
	logic w_strb_q; // Held low-lane strobe
	logic wr_en_c; // Write carried out this cycle
	logic [5:0] wr_idx_c; // Write register index
	byte_t kbd_ctrl_q; // Keyboard wake control
	byte_t proto_q; // Protocol control
	byte_t key_q [0:7]; // Stored key bytes
	byte_t kbd_cap_q; // Keyboard shift capture
	logic [2:0] mouse_cap_q; // Mouse shift capture
	logic [2:0] status_q; // Sticky event status
	logic [2:0] mask_q; // Interrupt mask
	logic [2:0] status_set_c; // Events this cycle
	logic [2:0] status_clr_c; // Write-one-to-clear bits
	logic cfg_wr_c; // Either wake control written
	kbd_mode_e kbd_mode_c; // Keyboard wake mode
	logic [3:0] kbd_sel_c; // Keyboard event field
	logic [2:0] mouse_sel_c; // Mouse event field
	logic parity_off_c; // Parity check skipped
	logic kbd_en_c, mouse_en_c; // Detection enabled
	logic kb_valid, kb_par; // Keyboard receiver outputs
	byte_t kb_byte;
	logic ms_valid, ms_par; // Mouse receiver outputs
	byte_t ms_byte;
	logic kb_ok_c, ms_ok_c; // Accepted bytes
	logic brk_q; // Next keyboard byte is a break code
	logic make_c; // Accepted byte is a plain make code
	logic cmp_valid_c; // Byte offered to the sequence matchers
	logic [3:0] len_c [0:2]; // Sequence length per matcher
	logic [2:0] kbd_hit_c; // Matcher completions
	logic kbd_match_c, mouse_match_c; // Wake conditions met
	logic [1:0] pkt_cnt_q; // Byte position in mouse packet
	logic [2:0] btn_q; // Buttons of current packet
	logic [2:0] prev_btn_q; // Buttons of previous packet
	logic move_q; // Movement seen in current packet
	logic [2:0] dbl_btn_q; // Buttons of last click
	logic [31:0] dclick_cnt_q; // Double-click window left
	logic pkt_done_c; // Mouse packet completed
	logic [2:0] press_c, dbl_c; // Clicks and double clicks
	logic wake_q, irq_q; // Output flops
	byte_t rd_byte_c; // Read mux result
	logic rd_err_c; // Unmapped read

	// ----------------------------------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------------------------------
	assign wr_en_c = !awready_out && !wready_out && !bvalid_out;
	assign wr_idx_c = aw_addr_q[7:2];

	// Address and data taken in either order, answer after both
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			awready_out <= 1'b1;
			wready_out <= 1'b1;
			bvalid_out <= 1'b0;
			bresp_out <= `RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= `RST_BYTE;
			w_strb_q <= 1'b0;
		end else begin
			if (awvalid_in && awready_out) begin
				aw_addr_q <= awaddr_in;
				awready_out <= 1'b0;
			end
			if (wvalid_in && wready_out) begin
				w_data_q <= wdata_in[7:0];
				w_strb_q <= wstrb_in[0];
				wready_out <= 1'b0;
			end
			if (wr_en_c) begin
				bvalid_out <= 1'b1;
				bresp_out <= (wr_idx_c > `IDX_WAKE_MASK || wr_idx_c < `IDX_KBD_WAKE_CTRL) ?
					`RESP_SLVERR : `RESP_OKAY;
			end else if (bvalid_out && bready_in) begin
				bvalid_out <= 1'b0;
				awready_out <= 1'b1;
				wready_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	// Control, keys and mask; read-only indexes ignore writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			kbd_ctrl_q <= `RST_KBD_WAKE_CTRL;
			proto_q <= `RST_PROTO_CTRL;
			mask_q <= 3'h0;
			for (int i = 0; i < 8; i++) begin
				key_q[i] <= `RST_BYTE;
			end
		end else if (wr_en_c && w_strb_q) begin
			if (wr_idx_c == `IDX_KBD_WAKE_CTRL) begin
				kbd_ctrl_q <= w_data_q;
			end else if (wr_idx_c == `IDX_PROTO_CTRL) begin
				proto_q <= w_data_q;
			end else if (wr_idx_c >= `IDX_KEY_FIRST && wr_idx_c <= `IDX_KEY_LAST) begin
				key_q[wr_idx_c[2:0]] <= w_data_q;
			end else if (wr_idx_c == `IDX_WAKE_MASK) begin
				mask_q <= w_data_q[2:0];
			end
		end
	end

	assign cfg_wr_c = wr_en_c && w_strb_q && (wr_idx_c == `IDX_KBD_WAKE_CTRL || wr_idx_c == `IDX_PROTO_CTRL);

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	assign kbd_mode_c = kbd_mode_e'(kbd_ctrl_q[`MSB_KBD_MODE:`LSB_KBD_MODE]);
	assign kbd_sel_c = proto_q[`MSB_KBD_SEL:0];
	assign mouse_sel_c = proto_q[`MSB_MOUSE_SEL:`LSB_MOUSE_SEL];
	assign parity_off_c = proto_q[`BIT_PARITY_OFF];
	// Keyboard field matters only in sequence mode; zero disables
	assign kbd_en_c = (kbd_mode_c == KBD_MODE_ANY) ||
		(kbd_mode_c == KBD_MODE_SEQ && kbd_sel_c != 4'h0) ||
		(kbd_mode_c == KBD_MODE_PM && kbd_ctrl_q[`MSB_PM_EVT:0] != 6'h00);
	assign mouse_en_c = mouse_sel_c != 3'h0;

	// ----------------------------------------------------------------
	// Link receivers
	// ----------------------------------------------------------------
	ps2_frame_receiver #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) kbd_rx (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.link_clk_in(kbd_clk_in),
		.link_data_in(kbd_data_in),
		.byte_valid_out(kb_valid),
		.byte_out(kb_byte),
		.parity_ok_out(kb_par)
	);

	ps2_frame_receiver #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mouse_rx (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.link_clk_in(mouse_clk_in),
		.link_data_in(mouse_data_in),
		.byte_valid_out(ms_valid),
		.byte_out(ms_byte),
		.parity_ok_out(ms_par)
	);

	// Bad parity drops the byte unless checking is off
	assign kb_ok_c = kbd_en_c && kb_valid && (kb_par || parity_off_c);
	assign ms_ok_c = mouse_en_c && ms_valid && (ms_par || parity_off_c);

	// ----------------------------------------------------------------
	// Shift captures
	// ----------------------------------------------------------------
	// Updated only while the matching detection is enabled
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			kbd_cap_q <= `RST_BYTE;
			mouse_cap_q <= 3'h0;
		end else begin
			if (kbd_en_c && kb_valid) begin
				kbd_cap_q <= kb_byte;
			end
			if (mouse_en_c && ms_valid) begin
				mouse_cap_q <= ms_byte[2:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Keyboard byte filtering
	// ----------------------------------------------------------------
	// Remember that the next byte ends a key, not starts one
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			brk_q <= 1'b0;
		end else if (kb_ok_c) begin
			brk_q <= (kb_byte == `SC_BREAK);
		end
	end

	assign make_c = kb_ok_c && !brk_q && kb_byte != `SC_BREAK && kb_byte != `SC_EXTEND;
	// Password mode sees make codes only, both shifts and Alt excluded
	assign cmp_valid_c = (kbd_mode_c == KBD_MODE_SEQ && kbd_sel_c[`BIT_PASSWORD]) ?
		(make_c && kb_byte != `SC_LSHIFT && kb_byte != `SC_RSHIFT && kb_byte != `SC_ALT) :
		kb_ok_c;

	// ----------------------------------------------------------------
	// Sequence lengths per matcher
	// ----------------------------------------------------------------
	// Sequence mode uses one matcher over all keys, power keys three
	always_comb begin
		len_c[0] = 4'h0;
		len_c[1] = 4'h0;
		len_c[2] = 4'h0;
		if (kbd_mode_c == KBD_MODE_SEQ && kbd_sel_c != 4'h0) begin
			len_c[0] = {1'b0, kbd_sel_c[2:0]} + 4'h1;
		end else if (kbd_mode_c == KBD_MODE_PM) begin
			len_c[0] = {2'h0, kbd_ctrl_q[1:0]};
			len_c[1] = {2'h0, kbd_ctrl_q[3:2]};
			len_c[2] = (kbd_ctrl_q[5:4] == 2'h3) ? 4'h0 : {2'h0, kbd_ctrl_q[5:4]};
		end
	end

	// ----------------------------------------------------------------
	// Sequence matchers
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 3; g++) begin : matcher
		localparam logic [2:0] BASE = 3'(g * 3);
		logic [3:0] idx_q; // Keys matched so far
		byte_t key_c; // Key expected next
		logic hit_c; // Byte matches expected key
		assign key_c = key_q[3'(BASE + idx_q[2:0])];
		assign hit_c = (key_c == `KEY_WILDCARD) || (key_c == kb_byte);
		assign kbd_hit_c[g] = cmp_valid_c && hit_c && len_c[g] != 4'h0 && 4'(idx_q + 4'h1) == len_c[g];

		// Walk stored keys in order, restart on miss or reconfiguration
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				idx_q <= 4'h0;
			end else if (cfg_wr_c || len_c[g] == 4'h0) begin
				idx_q <= 4'h0;
			end else if (cmp_valid_c) begin
				if (!hit_c || kbd_hit_c[g]) begin
					idx_q <= 4'h0;
				end else begin
					idx_q <= idx_q + 4'h1;
				end
			end
		end
	end

	assign kbd_match_c = (kbd_mode_c == KBD_MODE_ANY) ? make_c : (|kbd_hit_c);

	// ----------------------------------------------------------------
	// Mouse packet assembly
	// ----------------------------------------------------------------
	assign pkt_done_c = ms_ok_c && pkt_cnt_q == 2'h2;

	// Three-byte packets; first byte must carry the sync bit
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pkt_cnt_q <= 2'h0;
			btn_q <= 3'h0;
			move_q <= 1'b0;
			prev_btn_q <= 3'h0;
		end else if (cfg_wr_c) begin
			pkt_cnt_q <= 2'h0;
		end else if (ms_ok_c) begin
			case (pkt_cnt_q)
				2'h0: begin
					if (ms_byte[`MOUSE_SYNC_BIT]) begin
						btn_q <= ms_byte[2:0];
						move_q <= 1'b0;
						pkt_cnt_q <= 2'h1;
					end
				end
				2'h1: begin
					move_q <= ms_byte != `RST_BYTE;
					pkt_cnt_q <= 2'h2;
				end
				default: begin
					prev_btn_q <= btn_q;
					pkt_cnt_q <= 2'h0;
				end
			endcase
		end
	end

	assign press_c = pkt_done_c ? (btn_q & ~prev_btn_q) : 3'h0;
	assign dbl_c = press_c & dbl_btn_q & {3{dclick_cnt_q != 32'h0}};

	// ----------------------------------------------------------------
	// Double-click window
	// ----------------------------------------------------------------
	// Second press of the same button inside the window is a double
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dbl_btn_q <= 3'h0;
			dclick_cnt_q <= 32'h0;
		end else if (press_c != 3'h0) begin
			if (dbl_c != 3'h0) begin
				dbl_btn_q <= 3'h0;
				dclick_cnt_q <= 32'h0;
			end else begin
				dbl_btn_q <= press_c;
				dclick_cnt_q <= DCLICK_CYCLES;
			end
		end else if (dclick_cnt_q != 32'h0) begin
			dclick_cnt_q <= dclick_cnt_q - 32'h1;
		end
	end

	// Mouse wake condition by selected code
	always_comb begin
		case (mouse_sel_c)
			3'h1: mouse_match_c = pkt_done_c && (move_q || btn_q != 3'h0 || press_c != 3'h0);
			3'h2: mouse_match_c = press_c[0];
			3'h3: mouse_match_c = dbl_c[0];
			3'h4: mouse_match_c = press_c[1];
			3'h5: mouse_match_c = dbl_c[1];
			3'h6: mouse_match_c = press_c != 3'h0;
			3'h7: mouse_match_c = dbl_c != 3'h0;
			default: mouse_match_c = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Event status, interrupt and wake output
	// ----------------------------------------------------------------
	assign status_set_c[`EV_KBD] = kbd_match_c;
	assign status_set_c[`EV_MOUSE] = mouse_match_c;
	assign status_set_c[`EV_PARITY] = ((kbd_en_c && kb_valid && !kb_par) ||
		(mouse_en_c && ms_valid && !ms_par)) && !parity_off_c;
	assign status_clr_c = (wr_en_c && w_strb_q && wr_idx_c == `IDX_WAKE_STATUS) ? w_data_q[2:0] : 3'h0;

	// Sticky bits; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			status_q <= 3'h0;
		end else begin
			status_q <= (status_q & ~status_clr_c) | status_set_c;
		end
	end

	// Wake level held until the wake logic acknowledges it
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wake_q <= 1'b0;
		end else if (kbd_match_c || mouse_match_c) begin
			wake_q <= 1'b1;
		end else if (wake_ack_in) begin
			wake_q <= 1'b0;
		end
	end

	// Interrupt level from unmasked status
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	assign wake_event_out = wake_q;
	assign irq_out = irq_q;

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	// Read data by register index
	always_comb begin
		rd_byte_c = `RST_BYTE;
		rd_err_c = 1'b0;
		if (araddr_in[7:2] == `IDX_KBD_WAKE_CTRL) begin
			rd_byte_c = kbd_ctrl_q;
		end else if (araddr_in[7:2] == `IDX_PROTO_CTRL) begin
			rd_byte_c = proto_q;
		end else if (araddr_in[7:2] == `IDX_KBD_CAPTURE) begin
			rd_byte_c = kbd_cap_q;
		end else if (araddr_in[7:2] == `IDX_MOUSE_CAPTURE) begin
			rd_byte_c = {5'h00, mouse_cap_q};
		end else if (araddr_in[7:2] >= `IDX_KEY_FIRST && araddr_in[7:2] <= `IDX_KEY_LAST) begin
			rd_byte_c = key_q[araddr_in[4:2]];
		end else if (araddr_in[7:2] == `IDX_WAKE_STATUS) begin
			rd_byte_c = {5'h00, status_q};
		end else if (araddr_in[7:2] == `IDX_WAKE_MASK) begin
			rd_byte_c = {5'h00, mask_q};
		end else begin
			rd_err_c = 1'b1;
		end
	end

	// Address taken, data answered on the next edge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			arready_out <= 1'b1;
			rvalid_out <= 1'b0;
			rdata_out <= 32'h0000_0000;
			rresp_out <= `RESP_OKAY;
		end else if (arvalid_in && arready_out) begin
			arready_out <= 1'b0;
			rvalid_out <= 1'b1;
			rdata_out <= {24'h00_0000, rd_byte_c};
			rresp_out <= rd_err_c ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rvalid_out && rready_in) begin
			rvalid_out <= 1'b0;
			arready_out <= 1'b1;
		end
	end

endmodule : kbd_mouse_wake_config

//--- sim/ps2_link_model.sv
// Behavioural keyboard or mouse on one two-wire link.
// Assumes a listen-only block; both lines idle high by pull-up.
`timescale 1ns/10ps
module ps2_link_model (
	output logic link_clk_out,
	output logic link_data_out
);
	// Idle: both lines released high
	initial begin
		link_clk_out = 1;
		link_data_out = 1;
	end
	// Start, 8 data LSB first, odd parity (flipped when bad), stop; 80 ns bits
	task send(input logic [7:0] b, input logic bad);
		logic [10:0] f;
		f = {1'b1, ~^b ^ bad, b, 1'b0};
		// Step off the block's clock grid
		#1;
		for (int i = 0; i < 11; i++) begin
			link_data_out = f[i];
			#20 link_clk_out = 0;
			#40 link_clk_out = 1;
			#20;
		end
	endtask : send
endmodule : ps2_link_model

//--- sim/kbd_mouse_wake_config_sva.sv
// Checker for the wake block's bus answers and wake output.
// Assumes one clock domain; bound to the block's top below.
`timescale 1ns/10ps
module kbd_mouse_wake_config_sva (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic awvalid_in,
	input wire logic awready_out,
	input wire logic bvalid_out,
	input wire logic bready_in,
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	input wire logic arready_out,
	input wire logic [31:0] rdata_out,
	input wire logic [1:0] rresp_out,
	input wire logic rvalid_out,
	input wire logic rready_in,
	input wire logic wake_ack_in,
	input wire logic wake_event_out,
	input wire logic irq_out
);
	logic [7:0] ra_q; // Address of the read under way
	// Latch the read address when taken
	always_ff @(posedge clk_in) begin
		if (arvalid_in && arready_out) ra_q <= araddr_in;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_wake_hold; wake_event_out && !wake_ack_in |=> wake_event_out; endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
	property p_mouse_rsvd; rvalid_out && ra_q[7:2] == 6'h07 |-> rdata_out[31:3] == 0; endproperty
	a_mouse_rsvd: assert property (p_mouse_rsvd) else $error("mouse bits");
	property p_kbd_width; rvalid_out && ra_q[7:2] == 6'h06 |-> rdata_out[31:8] == 0; endproperty
	a_kbd_width: assert property (p_kbd_width) else $error("kbd bits");
	property p_rd_hold; rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read unstable");
	property p_rd_answer; arvalid_in && arready_out |=> rvalid_out && !arready_out; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read late");
	property p_rd_ok; rvalid_out && ra_q[7:2] inside {[6'h04:6'h11]} |-> rresp_out == 2'h0; endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("read resp");
	property p_b_hold; bvalid_out && !bready_in |=> bvalid_out; endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_aw_busy; awvalid_in && awready_out |=> !awready_out; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("aw ready");
	c_wake: cover property ($rose(wake_event_out));
	c_irq: cover property ($rose(irq_out));
	c_mouse: cover property (rvalid_out && ra_q[7:2] == 6'h07);
endmodule : kbd_mouse_wake_config_sva
bind kbd_mouse_wake_config kbd_mouse_wake_config_sva kbd_mouse_wake_config_sva_i (.*);

//--- sim/testbench.sv
// Self-checking bench: bus tasks, two link models, wake and irq checks.
// Assumes the link model and checker are compiled first.
`timescale 1ns/10ps
module testbench import kmw_pkg::*;;
	logic clk_in = 0, rst_in = 1, awvalid_in = 0, wvalid_in = 0, bready_in = 0;
	logic arvalid_in = 0, rready_in = 0, wake_ack_in = 0;
	logic [7:0] awaddr_in = 0, araddr_in = 0;
	logic [31:0] wdata_in = 0, rdata_out;
	logic [3:0] wstrb_in = 4'hF;
	logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, wake_event_out, irq_out;
	logic kbd_clk_in, kbd_data_in, mouse_clk_in, mouse_data_in;
	logic [1:0] bresp_out, rresp_out;
	int fail_count = 0, samples_checked = 0;
	initial forever #2.5 clk_in = ~clk_in;
	ps2_link_model kbd_dev (.link_clk_out(kbd_clk_in), .link_data_out(kbd_data_in));
	ps2_link_model mouse_dev (.link_clk_out(mouse_clk_in), .link_data_out(mouse_data_in));
	kbd_mouse_wake_config #(.DCLICK_CYCLES(200), .TIMEOUT_CYCLES(100)) kbd_mouse_wake_config_i (.*);
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		@(posedge clk_in);
		{awaddr_in, wdata_in} <= {a, 24'h0, d};
		{awvalid_in, wvalid_in, bready_in} <= 3'h7;
		do begin
			@(posedge clk_in);
			if (awready_out) awvalid_in <= 0;
			if (wready_out) wvalid_in <= 0;
		end while (!bvalid_out);
		bready_in <= 0;
		chk(bresp_out, r);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
		@(posedge clk_in);
		araddr_in <= a;
		{arvalid_in, rready_in} <= 2'h3;
		do begin
			@(posedge clk_in);
			if (arready_out) arvalid_in <= 0;
		end while (!rvalid_out);
		rready_in <= 0;
		chk(rdata_out, {24'h0, e});
		chk(rresp_out, r);
	endtask : rd
	// Check wake level, then acknowledge and check it cleared
	task wake_is(input logic e);
		repeat (10) @(posedge clk_in);
		chk(wake_event_out, e);
		wake_ack_in <= 1;
		@(posedge clk_in);
		wake_ack_in <= 0;
		@(posedge clk_in);
		chk(wake_event_out, 0);
	endtask : wake_is
	task pair(input logic bad);
		kbd_dev.send(8'h1C, bad);
		kbd_dev.send(8'h5A, 0);
	endtask : pair
	// Mouse packet with given first byte, no movement
	task pkt(input logic [7:0] b);
		mouse_dev.send(b, 0);
		mouse_dev.send(8'h00, 0);
		mouse_dev.send(8'h00, 0);
	endtask : pkt
	task t_defaults;
		rd(8'h14, 8'h10);
		rd(8'h18, 8'h00);
		rd(8'h1C, 8'h00);
		rd(8'h10, 8'h40);
		rd(8'h80, 8'h00, 2'h2);
		wr(8'h80, 8'h55, 2'h2);
	endtask : t_defaults
	// Mouse packet wakes on default setting, raises and clears irq
	task t_mouse;
		wr(8'h44, 8'h02);
		mouse_dev.send(8'h0D, 0);
		mouse_dev.send(8'h05, 0);
		mouse_dev.send(8'h05, 0);
		rd(8'h1C, 8'h05);
		chk(irq_out, 1);
		wake_is(1);
		wr(8'h40, 8'h02);
		repeat (3) @(posedge clk_in);
		chk(irq_out, 0);
		wr(8'h14, 8'h00);
		wr(8'h14, 8'h20);
		pkt(8'h08);
		wake_is(0);
		pkt(8'h09);
		wake_is(1);
		wr(8'h14, 8'h00);
	endtask : t_mouse
	task t_kbd;
		kbd_dev.send(8'h1C, 0);
		wake_is(1);
		wr(8'h10, 8'h00);
		wr(8'h20, 8'h1C);
		pair(0);
		wake_is(0);
		wr(8'h14, 8'h10);
		wr(8'h14, 8'h11);
		pair(1);
		wake_is(0);
		pair(0);
		wake_is(1);
		rd(8'h18, 8'h5A);
		wr(8'h14, 8'h90);
		wr(8'h14, 8'h91);
		pair(1);
		wake_is(1);
		wr(8'h24, 8'h5A);
		wr(8'h14, 8'h90);
		wr(8'h14, 8'h99);
		kbd_dev.send(8'h1C, 0);
		kbd_dev.send(8'h12, 0);
		kbd_dev.send(8'h5A, 0);
		wake_is(1);
		wr(8'h10, 8'h81);
		kbd_dev.send(8'h1C, 0);
		wake_is(1);
	endtask : t_kbd
	task conclude;
		if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 0;
		t_defaults();
		t_mouse();
		t_kbd();
		conclude();
	end
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule : testbench
